/* File: hw/ata_pkg.sv */
package ata_pkg;
  // Register selects (address lines with chip selects)
  localparam logic [2:0] CMD_DATA = 3'h0;
  localparam logic [2:0] CMD_ERR_FEAT = 3'h1;
  localparam logic [2:0] CMD_SECCNT = 3'h2;
  localparam logic [2:0] CMD_SECNUM = 3'h3;
  localparam logic [2:0] CMD_CYLLO = 3'h4;
  localparam logic [2:0] CMD_CYLHI = 3'h5;
  localparam logic [2:0] CMD_DRVHEAD = 3'h6;
  localparam logic [2:0] CMD_STAT_CMD = 3'h7;
  localparam logic [2:0] CTL_ALT_DEVCTL = 3'h6;
  localparam logic [2:0] CTL_DRVADDR = 3'h7;
  // Field positions and diagnostic command code
  localparam int DEVCTL_NIEN_BIT = 1;
  localparam int DEVCTL_SRST_BIT = 2;
  localparam int DRVHEAD_DEV_BIT = 4;
  localparam int STAT_BSY_BIT = 7;
  localparam int STAT_DRDY_BIT = 6;
  localparam logic [7:0] DIAG_CMD = 8'h90;
  // Reset and ready values
  localparam logic [7:0] STAT_RESET = 8'h80;
  localparam logic [7:0] STAT_READY = 8'h50;
  localparam logic [7:0] DEVCTL_RESET = 8'h00;
  // Timing (clock 250 MHz)
  localparam int CLK_MHZ = 250;
  localparam int DASP_ANNOUNCE_MS = 400;
  localparam int DASP_WAIT_MS = 450;
  localparam int PDIAG_NEG_MS = 1;
  localparam int PDIAG_POST_S = 30;
  localparam int DIAG_WAIT_S = 6;
  localparam int PIO_MIN_NS = 240;
  localparam int PIO_MIN_CYC = (PIO_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam longint MS_CYC = 64'(CLK_MHZ) * 1000;
  localparam longint DASP_WAIT_CYC = DASP_WAIT_MS * MS_CYC;
  localparam longint DIAG_WAIT_CYC = DIAG_WAIT_S * 1000 * MS_CYC;
  localparam longint PDIAG_POST_CYC = PDIAG_POST_S * 1000 * MS_CYC;
  localparam int HOST_DIV = 20;
  localparam int CLKDIV_HALF = 10;
endpackage

/* File: hw/ata_if.sv */
`timescale 1ns/10ps
interface ata_if;
  logic [15:0] dd_h;
  logic [15:0] dd_d;
  logic dd_h_oe;
  logic dd_d_oe;
  logic [2:0] da;
  logic cs0_n;
  logic cs1_n;
  logic dior_n;
  logic diow_n;
  logic reset_n;
  logic dmack_n;
  logic dmarq;
  logic dmarq_oe;
  logic iordy;
  logic iordy_oe;
  logic intrq;
  logic intrq_oe;
  logic dasp_o;
  logic dasp_oe;
  logic dasp_i;
  logic pdiag_o;
  logic pdiag_oe;
  logic pdiag_i;
  logic csel;

  modport dev (
    input dd_h, dd_h_oe, da, cs0_n, cs1_n, dior_n, diow_n, reset_n,
    input dmack_n, dasp_i, pdiag_i, csel,
    output dd_d, dd_d_oe, dmarq, dmarq_oe, iordy, iordy_oe,
    output intrq, intrq_oe, dasp_o, dasp_oe, pdiag_o, pdiag_oe
  );
  modport host (
    output dd_h, dd_h_oe, da, cs0_n, cs1_n, dior_n, diow_n, reset_n,
    output dmack_n,
    input dd_d, dd_d_oe, dmarq, dmarq_oe, iordy, iordy_oe,
    input intrq, intrq_oe, dasp_i, pdiag_i
  );
endinterface

/* File: hw/ata_sync.sv */
`timescale 1ns/10ps
module ata_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: hw/ata_device.sv */
`timescale 1ns/10ps
// How it works
// - Ultra DMA remaps IORDY, DIOR-, DIOW- lines
// - Sixteen-bit data bus, registers on low byte
// - Chip selects and address pick register
// - Host holds reset low at power up
// - Write strobe rising edge captures data
// - Read strobe low drives register data
// - INTRQ driven only selected and enabled
// - IRQ set by CPU, cleared by status read or command write
// - Device 1 announces presence on DASP-
// - Device 1 releases DASP- after first command
// - Device 1 negates then asserts PDIAG-
// - Diagnostics command restarts busy and diagnostics; PDIAG- stays released
// - Device 1 clears busy before PDIAG-
// - Device 0 posts alone once its diagnostic wait runs out
// - Device 1 releases PDIAG- after first command
// - Cable select picks device number
// - IORDY stretches cycles when not ready
// - DMARQ requests, DMACK- acknowledges
// - Receiver ready signal pauses burst
// - Data out latched on both strobe edges
// - Data in strobe toggles per word
// - Host STOP brackets the burst
// - Lines switch meaning with DMACK-
module ata_device
  import ata_pkg::*;
#(
  parameter longint DASP_WAIT = DASP_WAIT_CYC,
  parameter longint DIAG_WAIT = DIAG_WAIT_CYC,
  parameter longint POST_WAIT = PDIAG_POST_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Cable
  ata_if.dev bus,
  // Drive CPU side
  input wire logic cpu_irq,
  input wire logic cpu_ready,
  input wire logic udma_en,
  input wire logic diag_done,
  input wire logic [15:0] din_word,
  input wire logic din_valid,
  output logic din_ready,
  output logic [15:0] dout_word,
  output logic dout_valid,
  output logic [7:0] cmd_code,
  output logic cmd_valid,
  output logic dev1,
  input wire logic dma_req
);
  import ata_pkg::*;

  typedef enum logic [1:0] {
    DG_BUSY = 2'b00,
    DG_WAIT = 2'b01,
    DG_DONE = 2'b10
  } diag_t;

  typedef struct packed {
    logic [15:0] rd_data;
    logic rd_oe;
    logic [7:0] feat;
    logic [7:0] seccnt;
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
    logic [7:0] drvhead;
    logic [7:0] stat;
    logic [7:0] devctl;
    logic irq;
    logic dior_d;
    logic diow_d;
    logic hstb_d;
    logic [15:0] dout;
    logic dout_v;
    logic [7:0] cmd;
    logic cmd_v;
    logic dev1;
    logic first_cmd;
    logic dasp_drv;
    logic pdiag_drv;
    logic pdiag_rel;
    diag_t diag;
    logic [47:0] cnt;
    logic dstb;
    logic [5:0] pio_cnt;
    logic rst_d;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [15:0] dd_s;
  logic [2:0] da_s;
  logic cs0_s, cs1_s, dior_s, diow_s, rst_s, dmack_s, dasp_s, pdiag_s, csel_s;

  ata_sync #(.W(16)) u_dd (
    .clk_sys(clk_sys), .rstn(rstn), .d(bus.dd_h), .q(dd_s)
  );
  ata_sync #(.W(12)) u_ctl (
    .clk_sys(clk_sys), .rstn(rstn),
    .d({bus.da, bus.cs0_n, bus.cs1_n, bus.dior_n, bus.diow_n,
        bus.reset_n, bus.dmack_n, bus.dasp_i, bus.pdiag_i, bus.csel}),
    .q({da_s, cs0_s, cs1_s, dior_s, diow_s, rst_s, dmack_s, dasp_s,
        pdiag_s, csel_s})
  );

  function automatic logic [7:0] rd_reg(input state_t s, input logic c0,
                                        input logic c1, input logic [2:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (!c0) begin
      case (a)
        CMD_ERR_FEAT: v = 8'h00;
        CMD_SECCNT: v = s.seccnt;
        CMD_SECNUM: v = s.secnum;
        CMD_CYLLO: v = s.cyllo;
        CMD_CYLHI: v = s.cylhi;
        CMD_DRVHEAD: v = s.drvhead;
        CMD_STAT_CMD: v = s.stat;
        default: v = 8'h00;
      endcase
    end else if (!c1) begin
      case (a)
        CTL_ALT_DEVCTL: v = s.stat;
        CTL_DRVADDR: v = {2'b11, ~s.drvhead[3:0], s.dev1, ~s.dev1};
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  logic sel;
  logic udma;
  logic rd_fall;
  logic wr_rise;

  always_comb begin
    s_nxt = s_r;
    sel = (s_r.drvhead[DRVHEAD_DEV_BIT] == s_r.dev1);
    udma = udma_en && !dmack_s;
    rd_fall = s_r.dior_d && !dior_s && !udma;
    wr_rise = !s_r.diow_d && diow_s && !udma;
    s_nxt.dior_d = dior_s;
    s_nxt.diow_d = diow_s;
    s_nxt.hstb_d = dior_s;
    s_nxt.rst_d = rst_s;
    s_nxt.dout_v = 1'b0;
    s_nxt.cmd_v = 1'b0;
    s_nxt.rd_oe = !dior_s && sel && !udma && (!cs0_s || !cs1_s);
    if (cpu_irq) begin
      s_nxt.irq = 1'b1;
    end
    if (cpu_ready && s_r.diag == DG_DONE) begin
      s_nxt.stat = STAT_READY;
    end
    if (s_r.pio_cnt != 6'h00) begin
      s_nxt.pio_cnt = s_r.pio_cnt - 6'h01;
    end
    if (rd_fall && sel) begin
      s_nxt.rd_data = (!cs0_s && da_s == CMD_DATA) ?
                      din_word : {8'h00, rd_reg(s_r, cs0_s, cs1_s, da_s)};
      s_nxt.pio_cnt = 6'(PIO_MIN_CYC);
      if (!cs0_s && da_s == CMD_STAT_CMD && !cpu_irq) begin
        s_nxt.irq = 1'b0;
      end
    end
    if (wr_rise) begin
      if (!cs0_s) begin
        case (da_s)
          CMD_DATA: begin
            s_nxt.dout = dd_s;
            s_nxt.dout_v = sel;
          end
          CMD_ERR_FEAT: s_nxt.feat = dd_s[7:0];
          CMD_SECCNT: s_nxt.seccnt = dd_s[7:0];
          CMD_SECNUM: s_nxt.secnum = dd_s[7:0];
          CMD_CYLLO: s_nxt.cyllo = dd_s[7:0];
          CMD_CYLHI: s_nxt.cylhi = dd_s[7:0];
          CMD_DRVHEAD: s_nxt.drvhead = dd_s[7:0];
          CMD_STAT_CMD: begin
            if (sel) begin
              s_nxt.cmd = dd_s[7:0];
              s_nxt.cmd_v = 1'b1;
              if (!cpu_irq) begin
                s_nxt.irq = 1'b0;
              end
              if (s_r.dev1 && !s_r.first_cmd) begin
                s_nxt.first_cmd = 1'b1;
                s_nxt.dasp_drv = 1'b0;
                s_nxt.pdiag_rel = 1'b1;
              end
              if (dd_s[7:0] == DIAG_CMD) begin
                s_nxt.diag = DG_BUSY;
                s_nxt.cnt = '0;
                s_nxt.stat = STAT_RESET;
                s_nxt.pdiag_drv = 1'b0;
              end
            end
          end
          default: s_nxt.cmd = s_r.cmd;
        endcase
      end else if (!cs1_s && da_s == CTL_ALT_DEVCTL) begin
        s_nxt.devctl = dd_s[7:0];
      end
    end
    // Diagnostics / presence sequencing
    s_nxt.cnt = s_r.cnt + 48'h1;
    case (s_r.diag)
      DG_BUSY: begin
        if (diag_done) begin
          if (s_r.dev1) begin
            s_nxt.stat = STAT_READY;
            s_nxt.diag = DG_DONE;
          end else begin
            s_nxt.diag = DG_WAIT;
          end
        end
      end
      DG_WAIT: begin
        if (!pdiag_s || s_r.cnt >= 48'(DIAG_WAIT)) begin
          s_nxt.stat = STAT_READY;
          s_nxt.diag = DG_DONE;
        end
      end
      DG_DONE: begin
        if (s_r.dev1) begin
          s_nxt.pdiag_drv = 1'b1;
        end
      end
      default: s_nxt.diag = DG_BUSY;
    endcase
    if (s_r.dev1 && s_r.diag == DG_BUSY && s_r.cnt >= 48'(POST_WAIT)) begin
      s_nxt.stat = STAT_READY;
      s_nxt.diag = DG_DONE;
    end
    if (!s_r.dev1 && s_r.cnt >= 48'(DASP_WAIT) && !s_r.first_cmd) begin
      s_nxt.first_cmd = 1'b1;
    end
    // Hardware or software reset restarts the sequence; the extra cycle
    // after reset rises re-samples cable select once it has settled
    if (!rst_s || !s_r.rst_d || s_r.devctl[DEVCTL_SRST_BIT]) begin
      s_nxt.dev1 = csel_s;
      s_nxt.diag = DG_BUSY;
      s_nxt.cnt = '0;
      s_nxt.stat = STAT_RESET;
      s_nxt.irq = 1'b0;
      s_nxt.dasp_drv = csel_s && !s_r.first_cmd;
      s_nxt.pdiag_drv = 1'b0;
      if (!rst_s || !s_r.rst_d) begin
        s_nxt.first_cmd = 1'b0;
        s_nxt.pdiag_rel = 1'b0;
        s_nxt.devctl = DEVCTL_RESET;
      end
    end
    // Data in burst strobe toggles once per accepted word
    if (udma && !dior_s && din_valid && !diow_s) begin
      s_nxt.rd_data = din_word;
      s_nxt.dstb = !s_r.dstb;
    end
    // Data out: both host strobe edges
    if (udma && (s_r.hstb_d != dior_s) && !diow_s) begin
      s_nxt.dout = dd_s;
      s_nxt.dout_v = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{diag: DG_BUSY, stat: STAT_RESET, devctl: DEVCTL_RESET,
               dior_d: 1'b1, diow_d: 1'b1, hstb_d: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Data out: device drives only on reads, or in any burst while DIOR- is high
  assign bus.dd_d = s_r.rd_data;
  assign bus.dd_d_oe = s_r.rd_oe || (udma && dior_s && !dmack_s);
  assign bus.dmarq = dma_req;
  assign bus.dmarq_oe = sel;
  // IORDY doubles as DDMARDY- or DSTROBE in a burst
  assign bus.iordy = udma ? (bus.dd_h_oe ? !cpu_ready : s_r.dstb)
                          : (s_r.pio_cnt == 6'h00 && cpu_ready);
  assign bus.iordy_oe = sel;
  assign bus.intrq = s_r.irq;
  assign bus.intrq_oe = sel && !s_r.devctl[DEVCTL_NIEN_BIT];
  assign bus.dasp_o = 1'b0;
  assign bus.dasp_oe = s_r.dasp_drv || (!s_r.dev1 && !dasp_s && 1'b0);
  assign bus.pdiag_o = 1'b0;
  assign bus.pdiag_oe = s_r.pdiag_drv && !s_r.pdiag_rel;
  assign din_ready = udma && !dior_s && !diow_s;
  assign dout_word = s_r.dout;
  assign dout_valid = s_r.dout_v;
  assign cmd_code = s_r.cmd;
  assign cmd_valid = s_r.cmd_v;
  assign dev1 = s_r.dev1;
endmodule

/* File: hw/ata_host.sv */
`timescale 1ns/10ps
module ata_host
  import ata_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Cable
  ata_if.host bus,
  // Command port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic busy,
  output logic irq
);
  import ata_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_STRB = 2'b01,
    H_HOLD = 2'b10
  } hst_t;

  typedef struct packed {
    hst_t st;
    logic [15:0] dd;
    logic dd_oe;
    logic [3:0] adr;
    logic rdn;
    logic wrn;
    logic [5:0] cnt;
    logic [15:0] rdata;
    logic rst_n;
  } hstate_t;

  hstate_t s_r;
  hstate_t s_nxt;
  logic [15:0] dd_s;
  logic iordy_s;
  logic intrq_s;

  ata_sync #(.W(18)) u_in (
    .clk_sys(clk_sys), .rstn(rstn),
    .d({bus.dd_d, bus.iordy, bus.intrq && bus.intrq_oe}),
    .q({dd_s, iordy_s, intrq_s})
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_n = 1'b1;
    case (s_r.st)
      H_IDLE: begin
        if (wr || rd) begin
          s_nxt.adr = addr;
          s_nxt.dd = wdata;
          s_nxt.dd_oe = wr;
          s_nxt.rdn = !rd;
          s_nxt.wrn = !wr;
          s_nxt.cnt = 6'(HOST_DIV);
          s_nxt.st = H_STRB;
        end
      end
      H_STRB: begin
        if (s_r.cnt != 6'h0) begin
          s_nxt.cnt = s_r.cnt - 6'h1;
        end else if (iordy_s) begin
          if (!s_r.rdn) begin
            s_nxt.rdata = dd_s;
          end
          s_nxt.rdn = 1'b1;
          s_nxt.wrn = 1'b1;
          s_nxt.cnt = 6'(CLKDIV_HALF);
          s_nxt.st = H_HOLD;
        end
      end
      H_HOLD: begin
        if (s_r.cnt != 6'h0) begin
          s_nxt.cnt = s_r.cnt - 6'h1;
        end else begin
          s_nxt.dd_oe = 1'b0;
          s_nxt.st = H_IDLE;
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: H_IDLE, rdn: 1'b1, wrn: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.dd_h = s_r.dd;
  assign bus.dd_h_oe = s_r.dd_oe;
  assign bus.da = s_r.adr[2:0];
  assign bus.cs0_n = s_r.adr[3];
  assign bus.cs1_n = !s_r.adr[3];
  assign bus.dior_n = s_r.rdn;
  assign bus.diow_n = s_r.wrn;
  assign bus.reset_n = s_r.rst_n;
  assign bus.dmack_n = 1'b1;
  assign rdata = s_r.rdata;
  assign busy = (s_r.st != H_IDLE);
  assign irq = intrq_s;
endmodule

/* File: verif/ata_bus_props.sv */
`timescale 1ns/10ps
module ata_bus_props
  import ata_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Cable
  input wire logic [15:0] dd_h,
  input wire logic dd_h_oe,
  input wire logic dd_d_oe,
  input wire logic [2:0] da,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic reset_n,
  input wire logic dmack_n,
  input wire logic intrq_oe,
  input wire logic dasp_o,
  input wire logic dasp_oe,
  input wire logic pdiag_o,
  input wire logic pdiag_oe,
  input wire logic csel
);
  typedef struct packed {
    logic wlow;
    logic [4:0] wa;
    logic [7:0] wd;
    logic nien;
    logic sel;
    logic [3:0] rd_gap;
    logic [3:0] quiet;
  } chk_t;
  chk_t s_r;
  chk_t s_nxt;
  logic masked;

  // ****************************************
  // Shadow of interrupt enable and selection
  // ****************************************
  // Copied while the strobe is low, so a host that drops data on the
  // rising edge is still seen correctly
  always_comb begin
    s_nxt = s_r;
    s_nxt.wlow = !diow_n;
    if (!diow_n) begin
      s_nxt.wa = {cs1_n, cs0_n, da};
      s_nxt.wd = dd_h[7:0];
    end
    if (s_r.wlow && diow_n && s_r.wa == 5'h0e) begin
      s_nxt.nien = s_r.wd[DEVCTL_NIEN_BIT];
    end
    if (s_r.wlow && diow_n && s_r.wa == 5'h16) begin
      s_nxt.sel = s_r.wd[DRVHEAD_DEV_BIT];
    end
    if (!dior_n) begin
      s_nxt.rd_gap = 4'h0;
    end else if (s_r.rd_gap != 4'hf) begin
      s_nxt.rd_gap = s_r.rd_gap + 4'h1;
    end
    masked = s_r.nien || (s_r.sel != csel);
    if (!masked) begin
      s_nxt.quiet = 4'h0;
    end else if (s_r.quiet != 4'hf) begin
      s_nxt.quiet = s_r.quiet + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_wr_rise;
    !diow_n ##1 diow_n;
  endsequence
  sequence s_rd_held;
    (!dior_n && !(cs0_n && cs1_n) && s_r.sel == csel) [*8];
  endsequence

  a_reset_stays: assert property ($past(rstn) |-> reset_n)
    else $error("cable reset pulled low in operation");
  a_strobe_excl: assert property (dior_n || diow_n)
    else $error("read and write strobes low together");
  a_dmack_idle: assert property (dmack_n)
    else $error("dma acknowledge asserted by pio host");
  a_write_data: assert property (s_wr_rise |-> $past(dd_h_oe))
    else $error("write strobe rose without host data");
  a_addr_hold: assert property (!diow_n ##1 !diow_n |->
    $stable(da) && $stable(cs0_n) && $stable(cs1_n))
    else $error("address moved during write strobe");
  a_no_contend: assert property (!(dd_h_oe && dd_d_oe))
    else $error("both ends drive the data bus");
  a_read_drive: assert property (s_rd_held |-> dd_d_oe)
    else $error("device silent during read strobe");
  a_read_release: assert property (dd_d_oe |-> s_r.rd_gap < 4'h6)
    else $error("device drives data long after read");
  a_host_quiet: assert property (!dior_n |-> !dd_h_oe)
    else $error("host drives data during read");
  a_intrq_masked: assert property (s_r.quiet == 4'hf |-> !intrq_oe)
    else $error("interrupt driven while masked");
  a_dasp_drain: assert property (dasp_oe |-> !dasp_o)
    else $error("presence line driven high");
  a_pdiag_drain: assert property (pdiag_oe |-> !pdiag_o)
    else $error("diagnostic line driven high");
endmodule

/* File: verif/tb.sv */
`timescale 1ns/10ps
module tb;
  import ata_pkg::*;
  logic clk_sys;
  logic rstn;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic busy;
  logic irq;
  logic cpu_irq;
  logic cpu_ready;
  logic [15:0] din_word;
  logic diag_done;
  logic din_valid;
  logic [15:0] dout_word;
  logic dout_valid;
  logic [7:0] cmd_code;
  logic cmd_valid;
  logic dev1;
  logic [15:0] last_dout;
  logic [7:0] last_cmd;
  int err_total;
  int tests_run;
  int i;

  ata_if bus ();
  // Both open-drain lines carry a pull-up
  assign bus.dasp_i = ~(bus.dasp_oe & ~bus.dasp_o);
  assign bus.pdiag_i = ~(bus.pdiag_oe & ~bus.pdiag_o);

  ata_host i_ata_host (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .busy(busy), .irq(irq));
  ata_device #(.DASP_WAIT(1000), .DIAG_WAIT(1000), .POST_WAIT(1000))
    i_ata_device (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
    .cpu_irq(cpu_irq), .cpu_ready(cpu_ready), .udma_en(1'b0),
    .diag_done(diag_done), .din_word(din_word), .din_valid(din_valid),
    .din_ready(), .dout_word(dout_word), .dout_valid(dout_valid),
    .cmd_code(cmd_code), .cmd_valid(cmd_valid), .dev1(dev1),
    .dma_req(1'b0));
  ata_bus_props i_ata_bus_props (.clk_sys(clk_sys), .rstn(rstn),
    .dd_h(bus.dd_h), .dd_h_oe(bus.dd_h_oe), .dd_d_oe(bus.dd_d_oe),
    .da(bus.da), .cs0_n(bus.cs0_n), .cs1_n(bus.cs1_n),
    .dior_n(bus.dior_n), .diow_n(bus.diow_n), .reset_n(bus.reset_n),
    .dmack_n(bus.dmack_n), .intrq_oe(bus.intrq_oe), .dasp_o(bus.dasp_o),
    .dasp_oe(bus.dasp_oe), .pdiag_o(bus.pdiag_o),
    .pdiag_oe(bus.pdiag_oe), .csel(bus.csel));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (dout_valid === 1'b1) last_dout <= dout_word;
    if (cmd_valid === 1'b1) last_cmd <= cmd_code;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One command-port access; the host is busy for the whole cable cycle
  task automatic access(input logic w, input logic [3:0] a,
                        input logic [15:0] d);
    int n;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy !== 1'b0 && n < 500);
    @(posedge clk_sys);
    if (n >= 500) check("busy", 16'h0000, 16'h0001);
  endtask

  task automatic pulse(input bit diag);
    if (diag) diag_done <= 1'b1;
    else cpu_irq <= 1'b1;
    @(posedge clk_sys);
    diag_done <= 1'b0;
    cpu_irq <= 1'b0;
  endtask

  function automatic logic line(input int k);
    case (k)
      0: return irq;
      1: return bus.dasp_i;
      2: return bus.pdiag_i;
      default: return bus.intrq_oe;
    endcase
  endfunction

  task automatic wait_line(input int k, input logic v, input string what);
    int n;
    for (n = 0; n < 3000 && line(k) !== v; n++) @(posedge clk_sys);
    check(what, {15'h0000, v}, {15'h0000, line(k)});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    cpu_irq = 1'b0;
    cpu_ready = 1'b1;
    din_word = 16'hbeef;
    diag_done = 1'b0;
    din_valid = 1'b1;
    bus.csel = 1'b1;
    last_dout = 16'h0000;
    last_cmd = 8'h00;
    err_total = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("dev1", 16'h0001, {15'h0000, dev1});
    wait_line(1, 1'b0, "presence");
    check("pdiag busy", 16'h0001, {15'h0000, bus.pdiag_i});
    access(1'b1, 4'h6, 16'h0010);
    for (i = 2; i < 6; i++) access(1'b1, i[3:0], {8'h00, 8'(i * 17)});
    for (i = 2; i < 6; i++) begin
      access(1'b0, i[3:0], 16'h0000);
      check("reg", {8'h00, 8'(i * 17)}, {8'h00, rdata[7:0]});
    end
    access(1'b1, 4'h0, 16'h1234);
    check("data out", 16'h1234, last_dout);
    access(1'b0, 4'h0, 16'h0000);
    check("data in", 16'hbeef, rdata);
    pulse(1'b1);
    wait_line(2, 1'b0, "pdiag ready");
    access(1'b0, 4'h7, 16'h0000);
    check("bsy", 16'h0000, {15'h0000, rdata[STAT_BSY_BIT]});
    pulse(1'b0);
    wait_line(0, 1'b1, "irq set");
    access(1'b0, 4'h7, 16'h0000);
    wait_line(0, 1'b0, "irq status read");
    pulse(1'b0);
    wait_line(0, 1'b1, "irq set again");
    access(1'b1, 4'h7, 16'h00ec);
    check("command", 16'h00ec, {8'h00, last_cmd});
    wait_line(0, 1'b0, "irq command");
    wait_line(2, 1'b1, "pdiag released");
    wait_line(1, 1'b1, "dasp released");
    access(1'b1, 4'h7, {8'h00, DIAG_CMD});
    check("diag command", {8'h00, DIAG_CMD}, {8'h00, last_cmd});
    wait_line(2, 1'b1, "pdiag negated");
    access(1'b1, 4'he, 16'h0002);
    pulse(1'b0);
    repeat (20) @(posedge clk_sys);
    check("masked", 16'h0000, {15'h0000, bus.intrq_oe});
    access(1'b1, 4'he, 16'h0000);
    access(1'b1, 4'h6, 16'h0000);
    repeat (20) @(posedge clk_sys);
    check("deselected", 16'h0000, {15'h0000, bus.intrq_oe});
    access(1'b1, 4'h6, 16'h0010);
    wait_line(0, 1'b1, "irq reselect");
    finish_test();
  end

  initial begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule
